// ===== lbpwm_pkg.sv
// Purpose: Constants for the LED bypass PWM engine.
// Assumes: 32-bit AXI4-Lite register access with byte addresses.
// Notes: Each register takes one aligned word; unused bits read as zero.
`default_nettype none
package lbpwm_pkg;
  // Widths.
  localparam int NUM_CH = 12;
  localparam int CNT_W = 10;
  localparam int ADDR_W = 8;
  // Register byte offsets.
  localparam logic [7:0] OFS_ON_BASE = 8'h00;
  localparam logic [7:0] OFS_OFF_BASE = 8'h40;
  localparam logic [7:0] OFS_ENABLE = 8'h80;
  localparam logic [7:0] OFS_DIVIDER = 8'h84;
  localparam logic [7:0] OFS_SYSTEM_CONFIG_REG = 8'h88;
  localparam logic [7:0] OFS_FAULT = 8'h8c;
  localparam logic [7:0] OFS_COUNTER = 8'h90;
  localparam logic [7:0] OFS_SYNC_CMD = 8'h94;
  localparam logic [7:0] OFS_COMMIT = 8'h98;
  // Divider fields: exponent [2:0], decimal count minus one [11:4].
  localparam int DIV_EXP_LSB = 0;
  localparam int DIV_EXP_W = 3;
  localparam int DIV_DEC_LSB = 4;
  localparam int DIV_DEC_W = 8;
  // Divider reset: 2^4 times (0 + 1) is 16.
  localparam logic [2:0] DIV_EXP_RST = 3'h4;
  localparam logic [7:0] DIV_DEC_RST = 8'h00;
  // Config and command bits.
  localparam int CFG_MASTER_BIT = 0;
  localparam int CMD_GO_BIT = 0;
  // Other reset values.
  localparam logic [11:0] ENABLE_RST = 12'h000;
  localparam logic [9:0] COUNT_RST = 10'h000;
  // Master sync pulse: counts 1023 and 0 to 510, 512 in all.
  localparam logic [9:0] CNT_LAST = 10'h3ff;
  localparam logic [9:0] SYNC_HI_END = 10'h1ff;
  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ===== lbpwm_top.sv
// Purpose: Twelve-channel PWM timing engine for LED bypass switches.
// Assumes: One 200 MHz clock; comparator and sync pins are asynchronous.
// Notes: Registers sit behind an AXI4-Lite slave.
// Summary of operation
// (R1) PWM clock: power-of-two prescaler then decimal divider.
// (R2) Reset divisor is sixteen.
// (R3) Counter resets to zero, advances on PWM ticks only.
// (R4) Master drives half-period high pulse just before wrap.
// (R5) Non-master: synced sync rise clears counter and divider.
// (R6) External sync driver holds high one clock or more.
// (R7) One sync driver; others keep master bit zero.
// (R8) All devices share clock and divider settings.
// (R9) Broadcast sync command clears counter and divider.
// (R10) Open-forced switch latches until next on-then-off cycle.
// (R11) Open detection sets the channel fault bit.
// (R12) Zero write clears a fault bit; persisting fault sets it again.
// (R13) No short-threshold crossing by cycle end sets that fault bit.
// (R14) Faults reach the register at turn-off match.
// (R15) Frame writes commit together on good check, else discarded.
// (R16) Any 10-bit count may be written any time.
// (R17) New turn-off count goes active at next turn-on match.
// (R18) New turn-on count goes active at next turn-off match.
// (R19) Equal counts: turn-off match wins.
// (R20) Equal counts keep the LED off until they differ.
// (R21) Counter counts 0 to 1023 and wraps.
// (R22) On match opens bypass switch; off match closes it.
// (R23) Compare enable gates match effects on the switch.
// (R24) Divisor is prescaler ratio times decimal count; reset together.
`timescale 1ns/1ps
`default_nettype none
module lbpwm_top
  import lbpwm_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // AXI4-Lite write address and data.
  input wire logic [lbpwm_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read.
  input wire logic [lbpwm_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Phase alignment pin, split into its three signals.
  input wire logic sync_pin_in,
  output logic sync_pin_out,
  output logic sync_pin_oe_out,
  // Comparator flags and bypass switch drives, one bit per channel.
  input wire logic [lbpwm_pkg::NUM_CH-1:0] open_detect_in,
  input wire logic [lbpwm_pkg::NUM_CH-1:0] short_detect_in,
  output logic [lbpwm_pkg::NUM_CH-1:0] bypass_switch_out
);
  import lbpwm_pkg::*;

  // Top of the power-of-two prescaler for a given exponent.
  function automatic logic [7:0] presc_top(input logic [2:0] e);
    presc_top = 8'((9'h1 << e) - 9'h1);
  endfunction

  // Byte-lane merge of a write into an old word.
  function automatic logic [31:0] wmerge(input logic [31:0] old,
    input logic [31:0] d, input logic [3:0] s);
    for (int b = 0; b < 4; b++)
      wmerge[8*b +: 8] = s[b] ? d[8*b +: 8] : old[8*b +: 8];
  endfunction

  // True when an address falls in a channel bank at the given base.
  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
    in_bank = (a[7:6] == base[7:6]) && (a[5:2] < 4'(NUM_CH));
  endfunction

  // Reset release through two flip-flops.
  logic rst_meta_ff, rst_n_ff;
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // Pin synchronizers; the first stage feeds only the second.
  logic sync_meta_ff, sync_s_ff, sync_d_ff;
  logic [NUM_CH-1:0] open_meta_ff, open_s_ff, short_meta_ff, short_s_ff;
  always_ff @(posedge clk_in or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      sync_meta_ff <= 1'b0;
      sync_s_ff <= 1'b0;
      sync_d_ff <= 1'b0;
      open_meta_ff <= '0;
      open_s_ff <= '0;
      short_meta_ff <= '0;
      short_s_ff <= '0;
    end
    else
    begin
      sync_meta_ff <= sync_pin_in;
      sync_s_ff <= sync_meta_ff;
      sync_d_ff <= sync_s_ff;
      open_meta_ff <= open_detect_in;
      open_s_ff <= open_meta_ff;
      short_meta_ff <= short_detect_in;
      short_s_ff <= short_meta_ff;
    end
  end

  // Software-visible control state.
  logic [2:0] div_exp_ff, nxt_div_exp;
  logic [7:0] div_dec_ff, nxt_div_dec;
  logic master_ff, nxt_master;
  logic [NUM_CH-1:0] enable_ff, nxt_enable;
  logic [NUM_CH-1:0] fault_ff, nxt_fault;
  logic [9:0] stage_on_ff [NUM_CH];
  logic [9:0] stage_off_ff [NUM_CH];
  logic [9:0] nxt_stage_on [NUM_CH];
  logic [9:0] nxt_stage_off [NUM_CH];
  logic [NUM_CH-1:0] dirty_on_ff, dirty_off_ff, nxt_dirty_on, nxt_dirty_off;
  logic commit_go, sync_cmd, fault_wr;
  logic [NUM_CH-1:0] fault_keep, fault_set;

  // Bus slave state.
  logic aw_have_ff, w_have_ff, nxt_aw_have, nxt_w_have;
  logic [7:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic nxt_awready, nxt_wready, nxt_bvalid, nxt_arready, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic do_wr;

  // Timing state.
  logic [7:0] presc_ff, nxt_presc, dec_ff, nxt_dec;
  logic [9:0] pcnt_ff, nxt_pcnt;
  logic step_ff, nxt_step, sync_out_ff, nxt_sync_out, sync_clr;

  // Channel state.
  logic [9:0] act_on_ff [NUM_CH];
  logic [9:0] act_off_ff [NUM_CH];
  logic [9:0] shd_on_ff [NUM_CH];
  logic [9:0] shd_off_ff [NUM_CH];
  logic [9:0] nxt_act_on [NUM_CH];
  logic [9:0] nxt_act_off [NUM_CH];
  logic [9:0] nxt_shd_on [NUM_CH];
  logic [9:0] nxt_shd_off [NUM_CH];
  logic [NUM_CH-1:0] pend_on_ff, pend_off_ff, nxt_pend_on, nxt_pend_off;
  logic [NUM_CH-1:0] led_ff, latch_ff, saw_on_ff, open_pend_ff;
  logic [NUM_CH-1:0] cyc_on_ff, short_ok_ff, bypass_ff;
  logic [NUM_CH-1:0] nxt_led, nxt_latch, nxt_saw_on, nxt_open_pend;
  logic [NUM_CH-1:0] nxt_cyc_on, nxt_short_ok, nxt_bypass;

  // Bus handshakes; address and data taken in either order.
  always_comb
  begin
    nxt_aw_have = aw_have_ff;
    nxt_w_have = w_have_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff && !s_axi_bready_in;
    nxt_bresp = bresp_ff;
    do_wr = aw_have_ff && w_have_ff && !bvalid_ff;
    if (s_axi_awvalid_in && awready_ff)
    begin
      nxt_aw_have = 1'b1;
      nxt_awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && wready_ff)
    begin
      nxt_w_have = 1'b1;
      nxt_wdata = s_axi_wdata_in;
      nxt_wstrb = s_axi_wstrb_in;
    end
    if (do_wr)
    begin
      nxt_aw_have = 1'b0;
      nxt_w_have = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = RESP_OKAY;
      if (!(in_bank(awaddr_ff, OFS_ON_BASE) ||
          in_bank(awaddr_ff, OFS_OFF_BASE) || awaddr_ff == OFS_ENABLE ||
          awaddr_ff == OFS_DIVIDER || awaddr_ff == OFS_SYSTEM_CONFIG_REG ||
          awaddr_ff == OFS_FAULT || awaddr_ff == OFS_COUNTER ||
          awaddr_ff == OFS_SYNC_CMD || awaddr_ff == OFS_COMMIT))
        nxt_bresp = RESP_SLVERR;
    end
    nxt_awready = !nxt_aw_have && !nxt_bvalid;
    nxt_wready = !nxt_w_have && !nxt_bvalid;
    nxt_rvalid = rvalid_ff && !s_axi_rready_in;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (s_axi_arvalid_in && arready_ff)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      nxt_rdata = 32'h0000_0000;
      if (in_bank(s_axi_araddr_in, OFS_ON_BASE))
        nxt_rdata[9:0] = act_on_ff[s_axi_araddr_in[5:2]];
      else if (in_bank(s_axi_araddr_in, OFS_OFF_BASE))
        nxt_rdata[9:0] = act_off_ff[s_axi_araddr_in[5:2]];
      else if (s_axi_araddr_in == OFS_ENABLE)
        nxt_rdata[NUM_CH-1:0] = enable_ff;
      else if (s_axi_araddr_in == OFS_DIVIDER)
      begin
        nxt_rdata[DIV_EXP_LSB +: DIV_EXP_W] = div_exp_ff;
        nxt_rdata[DIV_DEC_LSB +: DIV_DEC_W] = div_dec_ff;
      end
      else if (s_axi_araddr_in == OFS_SYSTEM_CONFIG_REG)
        nxt_rdata[CFG_MASTER_BIT] = master_ff;
      else if (s_axi_araddr_in == OFS_FAULT)
        nxt_rdata[NUM_CH-1:0] = fault_ff; // R11
      else if (s_axi_araddr_in == OFS_COUNTER)
        nxt_rdata[9:0] = pcnt_ff;
      else if (s_axi_araddr_in != OFS_SYNC_CMD &&
               s_axi_araddr_in != OFS_COMMIT)
        nxt_rresp = RESP_SLVERR;
    end
    nxt_arready = !nxt_rvalid;
  end

  // Register writes; count writes land in staging until a commit.
  always_comb
  begin
    logic [31:0] w;
    w = 32'h0000_0000;
    nxt_div_exp = div_exp_ff;
    nxt_div_dec = div_dec_ff;
    nxt_master = master_ff;
    nxt_enable = enable_ff;
    nxt_dirty_on = dirty_on_ff;
    nxt_dirty_off = dirty_off_ff;
    nxt_stage_on = stage_on_ff;
    nxt_stage_off = stage_off_ff;
    commit_go = 1'b0;
    sync_cmd = 1'b0;
    fault_wr = 1'b0;
    fault_keep = '1;
    if (do_wr)
    begin
      if (in_bank(awaddr_ff, OFS_ON_BASE))
      begin
        w = wmerge({22'h0, stage_on_ff[awaddr_ff[5:2]]}, wdata_ff, wstrb_ff);
        nxt_stage_on[awaddr_ff[5:2]] = w[9:0]; // R16
        nxt_dirty_on[awaddr_ff[5:2]] = 1'b1;
      end
      else if (in_bank(awaddr_ff, OFS_OFF_BASE))
      begin
        w = wmerge({22'h0, stage_off_ff[awaddr_ff[5:2]]}, wdata_ff, wstrb_ff);
        nxt_stage_off[awaddr_ff[5:2]] = w[9:0]; // R16
        nxt_dirty_off[awaddr_ff[5:2]] = 1'b1;
      end
      else if (awaddr_ff == OFS_ENABLE)
      begin
        w = wmerge({20'h0, enable_ff}, wdata_ff, wstrb_ff);
        nxt_enable = w[NUM_CH-1:0];
      end
      else if (awaddr_ff == OFS_DIVIDER)
      begin
        w = wmerge({20'h0, div_dec_ff, 1'b0, div_exp_ff}, wdata_ff, wstrb_ff);
        nxt_div_exp = w[DIV_EXP_LSB +: DIV_EXP_W]; // R1
        nxt_div_dec = w[DIV_DEC_LSB +: DIV_DEC_W]; // R1
      end
      else if (awaddr_ff == OFS_SYSTEM_CONFIG_REG)
      begin
        w = wmerge({31'h0, master_ff}, wdata_ff, wstrb_ff);
        nxt_master = w[CFG_MASTER_BIT];
      end
      else if (awaddr_ff == OFS_FAULT)
      begin
        w = wmerge({20'h0, fault_ff}, wdata_ff, wstrb_ff);
        fault_wr = 1'b1;
        fault_keep = w[NUM_CH-1:0]; // R12
      end
      else if (awaddr_ff == OFS_SYNC_CMD)
        sync_cmd = wdata_ff[CMD_GO_BIT] && wstrb_ff[0]; // R9
      else if (awaddr_ff == OFS_COMMIT)
      begin
        // Bit 0 carries the frame check result: 1 commits, 0 discards.
        commit_go = wdata_ff[CMD_GO_BIT] && wstrb_ff[0]; // R15
        nxt_dirty_on = '0; // R15
        nxt_dirty_off = '0; // R15
      end
    end
    // Set wins over a software clear in the same cycle.
    nxt_fault = (fault_wr ? (fault_ff & fault_keep) : fault_ff) | fault_set;
  end

  // Divider and period counter; divisor is 2^exp times (dec + 1).
  always_comb
  begin
    sync_clr = (!master_ff && sync_s_ff && !sync_d_ff) || sync_cmd; // R5 R9
    nxt_presc = presc_ff;
    nxt_dec = dec_ff;
    nxt_pcnt = pcnt_ff;
    nxt_step = 1'b0;
    if (sync_clr)
    begin
      nxt_presc = 8'h00; // R24
      nxt_dec = 8'h00; // R24
      nxt_pcnt = COUNT_RST; // R5
      nxt_step = 1'b1;
    end
    else if (presc_ff >= presc_top(div_exp_ff)) // R1
    begin
      nxt_presc = 8'h00;
      if (dec_ff >= div_dec_ff) // R24
      begin
        nxt_dec = 8'h00;
        nxt_pcnt = pcnt_ff + 10'h001; // R3 R21
        nxt_step = 1'b1;
      end
      else
        nxt_dec = dec_ff + 8'h01;
    end
    else
      nxt_presc = presc_ff + 8'h01;
    // Master pulse: count 1023 and counts 0 to 510.
    nxt_sync_out = master_ff &&
      (pcnt_ff == CNT_LAST || pcnt_ff < SYNC_HI_END); // R4
  end

  // Per-channel compare, shadow transfer, open latch and fault capture.
  always_comb
  begin
    logic on_hit, off_hit, open_ev;
    on_hit = 1'b0;
    off_hit = 1'b0;
    open_ev = 1'b0;
    nxt_act_on = act_on_ff;
    nxt_act_off = act_off_ff;
    nxt_shd_on = shd_on_ff;
    nxt_shd_off = shd_off_ff;
    nxt_pend_on = pend_on_ff;
    nxt_pend_off = pend_off_ff;
    nxt_led = led_ff;
    nxt_latch = latch_ff;
    nxt_saw_on = saw_on_ff;
    nxt_open_pend = open_pend_ff;
    nxt_cyc_on = cyc_on_ff;
    nxt_short_ok = short_ok_ff;
    fault_set = '0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      on_hit = step_ff && (pcnt_ff == act_on_ff[i]);
      off_hit = step_ff && (pcnt_ff == act_off_ff[i]);
      open_ev = open_s_ff[i] && led_ff[i];
      // Shadow loads: a fresh commit replaces any older pending value.
      if (commit_go && dirty_on_ff[i])
      begin
        nxt_shd_on[i] = stage_on_ff[i]; // R15
        nxt_pend_on[i] = 1'b1;
      end
      else if (off_hit && pend_on_ff[i])
      begin
        nxt_act_on[i] = shd_on_ff[i]; // R18
        nxt_pend_on[i] = 1'b0;
      end
      if (commit_go && dirty_off_ff[i])
      begin
        nxt_shd_off[i] = stage_off_ff[i]; // R15
        nxt_pend_off[i] = 1'b1;
      end
      else if (on_hit && pend_off_ff[i])
      begin
        nxt_act_off[i] = shd_off_ff[i]; // R17
        nxt_pend_off[i] = 1'b0;
      end
      // Turn-off match is tested first so equal counts hold the LED off.
      if (!enable_ff[i])
        nxt_led[i] = 1'b0; // R23
      else if (off_hit)
        nxt_led[i] = 1'b0; // R19 R20 R22
      else if (on_hit)
        nxt_led[i] = 1'b1; // R22
      // Open latch releases after a later on match then off match.
      if (open_ev)
      begin
        nxt_latch[i] = 1'b1; // R10
        nxt_saw_on[i] = 1'b0;
      end
      else if (latch_ff[i])
      begin
        if (on_hit && enable_ff[i])
          nxt_saw_on[i] = 1'b1;
        if (off_hit && saw_on_ff[i])
        begin
          nxt_latch[i] = 1'b0; // R10
          nxt_saw_on[i] = 1'b0;
        end
      end
      if (open_ev)
        nxt_open_pend[i] = 1'b1;
      if (led_ff[i] && !latch_ff[i])
        nxt_cyc_on[i] = 1'b1;
      if (short_s_ff[i] && led_ff[i] && !latch_ff[i])
        nxt_short_ok[i] = 1'b1;
      // Faults reach the register at the turn-off match.
      if (off_hit)
      begin
        fault_set[i] = open_pend_ff[i] || open_ev ||
          (cyc_on_ff[i] && !short_ok_ff[i]); // R11 R13 R14
        nxt_open_pend[i] = 1'b0;
        nxt_cyc_on[i] = 1'b0;
        nxt_short_ok[i] = 1'b0;
      end
    end
    // Switch closed means LED dark; the latch forces it closed.
    nxt_bypass = ~nxt_led | nxt_latch;
  end

  // Register every group of state.
  always_ff @(posedge clk_in or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
      div_exp_ff <= DIV_EXP_RST; // R2
      div_dec_ff <= DIV_DEC_RST; // R2
      master_ff <= 1'b0;
      enable_ff <= ENABLE_RST;
      fault_ff <= '0;
      dirty_on_ff <= '0;
      dirty_off_ff <= '0;
      presc_ff <= 8'h00;
      dec_ff <= 8'h00;
      pcnt_ff <= COUNT_RST; // R3
      step_ff <= 1'b0;
      sync_out_ff <= 1'b0;
      pend_on_ff <= '0;
      pend_off_ff <= '0;
      led_ff <= '0;
      latch_ff <= '0;
      saw_on_ff <= '0;
      open_pend_ff <= '0;
      cyc_on_ff <= '0;
      short_ok_ff <= '0;
      bypass_ff <= '1;
      for (int i = 0; i < NUM_CH; i++)
      begin
        stage_on_ff[i] <= COUNT_RST;
        stage_off_ff[i] <= COUNT_RST;
        act_on_ff[i] <= COUNT_RST;
        act_off_ff[i] <= COUNT_RST;
        shd_on_ff[i] <= COUNT_RST;
        shd_off_ff[i] <= COUNT_RST;
      end
    end
    else
    begin
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      div_exp_ff <= nxt_div_exp;
      div_dec_ff <= nxt_div_dec;
      master_ff <= nxt_master;
      enable_ff <= nxt_enable;
      fault_ff <= nxt_fault;
      dirty_on_ff <= nxt_dirty_on;
      dirty_off_ff <= nxt_dirty_off;
      stage_on_ff <= nxt_stage_on;
      stage_off_ff <= nxt_stage_off;
      presc_ff <= nxt_presc;
      dec_ff <= nxt_dec;
      pcnt_ff <= nxt_pcnt;
      step_ff <= nxt_step;
      sync_out_ff <= nxt_sync_out;
      act_on_ff <= nxt_act_on;
      act_off_ff <= nxt_act_off;
      shd_on_ff <= nxt_shd_on;
      shd_off_ff <= nxt_shd_off;
      pend_on_ff <= nxt_pend_on;
      pend_off_ff <= nxt_pend_off;
      led_ff <= nxt_led;
      latch_ff <= nxt_latch;
      saw_on_ff <= nxt_saw_on;
      open_pend_ff <= nxt_open_pend;
      cyc_on_ff <= nxt_cyc_on;
      short_ok_ff <= nxt_short_ok;
      bypass_ff <= nxt_bypass;
    end
  end

  // Outputs straight from flip-flops.
  assign s_axi_awready_out = awready_ff;
  assign s_axi_wready_out = wready_ff;
  assign s_axi_bvalid_out = bvalid_ff;
  assign s_axi_bresp_out = bresp_ff;
  assign s_axi_arready_out = arready_ff;
  assign s_axi_rvalid_out = rvalid_ff;
  assign s_axi_rresp_out = rresp_ff;
  assign s_axi_rdata_out = rdata_ff;
  assign sync_pin_out = sync_out_ff; // R4
  assign sync_pin_oe_out = master_ff; // R4
  assign bypass_switch_out = bypass_ff;
endmodule // lbpwm_top
`default_nettype wire

// ===== lbpwm_assertions.sv
// Purpose: Bus and pin checks for the PWM engine.
// Assumes: The bench offers write address and data in one cycle.
// Notes: Enable and master bits are tracked from bus writes.
`timescale 1ns/1ps
`default_nettype none
module lbpwm_chk
  import lbpwm_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // Register bus.
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Pins.
  input wire logic sync_pin_out,
  input wire logic sync_pin_oe_out,
  input wire logic [11:0] bypass_switch_out
);
  logic [11:0] en_ff;
  logic mst_ff;
  logic bad_ff;
  wire logic wr_go = s_axi_awvalid_in && s_axi_awready_out &&
    s_axi_wvalid_in && s_axi_wready_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Copies of bits that show at the pins.
  always_ff @(posedge clk_in or negedge resetn_in)
    if (!resetn_in)
      {en_ff, mst_ff, bad_ff} <= '0;
    else if (wr_go)
    begin
      if (s_axi_awaddr_in == OFS_ENABLE) en_ff <= s_axi_wdata_in[11:0];
      if (s_axi_awaddr_in == OFS_SYSTEM_CONFIG_REG) mst_ff <= s_axi_wdata_in[0];
      bad_ff <= s_axi_awaddr_in >= 8'h9c;
    end
  // Bus answers come promptly and stand until taken.
  b_after_wr_a: assert property (wr_go |-> ##[1:2] s_axi_bvalid_out)
    else $error("write response missing");
  b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped");
  r_after_ar_a: assert property (s_axi_arvalid_in && s_axi_arready_out
    |-> ##[1:2] s_axi_rvalid_out) else $error("read data missing");
  r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped");
  ar_block_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read taken while busy");
  w_block_a: assert property (s_axi_bvalid_out
    |-> !s_axi_awready_out && !s_axi_wready_out) else $error("write busy");
  bad_resp_a: assert property (s_axi_bvalid_out && bad_ff
    |-> s_axi_bresp_out == RESP_SLVERR) else $error("unmapped write okay");
  // Three cycles of slack cover the bypass output register.
  en_gate_a: assert property (en_ff == 12'h000
    && $past(en_ff, 3) == 12'h000 |-> bypass_switch_out == 12'hfff)
    else $error("disabled channel lit");
  oe_track_a: assert property (mst_ff == $past(mst_ff, 3)
    |-> sync_pin_oe_out == mst_ff) else $error("sync drive wrong");
  c_write_c: cover property (wr_go);
  c_sync_c: cover property ($rose(sync_pin_out));
  c_lit_c: cover property ($fell(bypass_switch_out[0]));
endmodule // lbpwm_chk
bind lbpwm_top lbpwm_chk i_lbpwm_chk (.*);
`default_nettype wire

// ===== lbpwm_peer.sv
// Purpose: Peer device on the sync line.
// Assumes: Same system clock as the device.
// Notes: The line is pulled low when nobody drives it.
`timescale 1ns/1ps
`default_nettype none
module lbpwm_peer (
  // Clock and pulse request.
  input wire logic clk_in,
  input wire logic kick_in,
  // Device side of the line.
  input wire logic dev_out_in,
  input wire logic dev_oe_in,
  output logic line_out
);
  logic [1:0] hold_ff = 2'h0;
  // Two clocks high so a synchroniser cannot miss the edge.
  always_ff @(posedge clk_in)
    hold_ff <= kick_in ? 2'h2 : hold_ff - {1'b0, hold_ff != 2'h0};
  // The peer yields while the device drives, so there is one driver.
  assign line_out = dev_oe_in ? dev_out_in : hold_ff != 2'h0;
endmodule // lbpwm_peer
`default_nettype wire

// ===== tb_lbpwm_top.sv
// Purpose: Register tests of the PWM engine.
// Assumes: Divisor set to six early, so a period is 6144 clocks.
// Notes: Bypass high means the LED is dark.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin \
  error_cnt++; $display("BAD %s exp %0h got %0h", nm, e, s); end end
module tb_lbpwm_top;
  import lbpwm_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
  logic [31:0] s_axi_wdata_in = 32'h0, d;
  logic [3:0] s_axi_wstrb_in = 4'hf;
  logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
  logic s_axi_arvalid_in = 0, s_axi_rready_in = 0, kick = 0, sel = 0;
  logic [11:0] open_detect_in = 12'h000, short_detect_in = 12'hfff;
  wire logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  wire logic s_axi_arready_out, s_axi_rvalid_out, sync_pin_in;
  wire logic sync_pin_out, sync_pin_oe_out;
  wire logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [1:0] r;
  wire logic [31:0] s_axi_rdata_out;
  wire logic [11:0] bypass_switch_out;
  wire logic mon = sel ? bypass_switch_out[0] : sync_pin_out;
  int error_cnt = 0, n_tests = 0, n;
  lbpwm_top i_lbpwm_top (.*);
  lbpwm_peer i_lbpwm_peer (.clk_in(clk_in), .kick_in(kick),
    .dev_out_in(sync_pin_out), .dev_oe_in(sync_pin_oe_out),
    .line_out(sync_pin_in));
  initial forever #2.5 clk_in = ~clk_in;
  task automatic give_verdict;
    $display("errors %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Levels are sampled at the falling edge, clear of launch races.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ha, hw, hb;
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= v;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
    hb = 0;
    while (!hb)
    begin
      @(negedge clk_in);
      ha = s_axi_awvalid_in && s_axi_awready_out;
      hw = s_axi_wvalid_in && s_axi_wready_out;
      hb = s_axi_bvalid_out;
      r = s_axi_bresp_out;
      @(posedge clk_in);
      if (ha) s_axi_awvalid_in <= 1'b0;
      if (hw) s_axi_wvalid_in <= 1'b0;
    end
    s_axi_bready_in <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    logic ha, hr;
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
    hr = 0;
    while (!hr)
    begin
      @(negedge clk_in);
      ha = s_axi_arvalid_in && s_axi_arready_out;
      hr = s_axi_rvalid_out;
      d = s_axi_rdata_out;
      r = s_axi_rresp_out;
      @(posedge clk_in);
      if (ha) s_axi_arvalid_in <= 1'b0;
    end
    s_axi_rready_in <= 1'b0;
  endtask
  // Clocks in the next full stretch of mon at lv.
  task automatic span(input logic lv);
    n = 0;
    do @(negedge clk_in); while (mon === lv);
    do @(negedge clk_in); while (mon !== lv);
    do begin n++; @(negedge clk_in); end while (mon === lv);
  endtask
  initial
  begin
    #480000;
    error_cnt++;
    give_verdict;
  end
  initial
  begin
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    `CHK("bypass", 12'hfff, bypass_switch_out)
    rdr(OFS_DIVIDER);
    `CHK("divider", 32'h4, d)
    rdr(8'hfc);
    `CHK("unmapped", RESP_SLVERR, r)
    wr(8'hfc, 32'h0);
    `CHK("unmapped wr", RESP_SLVERR, r)
    wr(OFS_DIVIDER, 32'h21);
    wr(OFS_SYSTEM_CONFIG_REG, 32'h1);
    @(negedge clk_in);
    `CHK("drive", 1'b1, sync_pin_oe_out)
    span(1'b1);
    `CHK("sync high", 512 * 6, n)
    wr(OFS_SYSTEM_CONFIG_REG, 32'h0);
    repeat (700) @(posedge clk_in);
    kick <= 1'b1;
    @(posedge clk_in) kick <= 1'b0;
    repeat (4) @(posedge clk_in);
    rdr(OFS_COUNTER);
    `CHK("pin sync", 1'b1, d[9:0] < 10'h3)
    repeat (700) @(posedge clk_in);
    wr(OFS_SYNC_CMD, 32'h1);
    rdr(OFS_COUNTER);
    `CHK("cmd sync", 1'b1, d[9:0] < 10'h3)
    n = d[9:0];
    repeat (60) @(posedge clk_in);
    rdr(OFS_COUNTER);
    `CHK("advance", 1'b1, d[9:0] - n inside {[9:12]})
    wr(OFS_ON_BASE, 32'h4);
    wr(OFS_OFF_BASE, 32'h8);
    wr(OFS_COMMIT, 32'h1);
    wr(OFS_ENABLE, 32'h1);
    sel <= 1'b1;
    repeat (12300) @(posedge clk_in);
    span(1'b0);
    `CHK("lit", 24, n)
    wr(OFS_ON_BASE, 32'h2);
    wr(OFS_COMMIT, 32'h0);
    repeat (6200) @(posedge clk_in);
    span(1'b0);
    `CHK("discard", 24, n)
    open_detect_in <= 12'h001;
    repeat (6200) @(posedge clk_in);
    rdr(OFS_FAULT);
    `CHK("open", 32'h1, d)
    open_detect_in <= 12'h000;
    wr(OFS_FAULT, 32'h0);
    rdr(OFS_FAULT);
    `CHK("clear", 32'h0, d)
    short_detect_in <= 12'h000;
    wr(OFS_FAULT, 32'h0);
    repeat (12400) @(posedge clk_in);
    rdr(OFS_FAULT);
    `CHK("short", 32'h1, d)
    wr(OFS_ON_BASE, 32'h8);
    wr(OFS_COMMIT, 32'h1);
    repeat (12300) @(posedge clk_in);
    n = 0;
    repeat (6144)
    begin
      @(negedge clk_in);
      n += (bypass_switch_out[0] !== 1'b1);
    end
    `CHK("equal", 0, n)
    wr(OFS_ENABLE, 32'h0);
    repeat (4) @(negedge clk_in);
    `CHK("off", 12'hfff, bypass_switch_out)
    give_verdict;
  end
endmodule // tb_lbpwm_top
`default_nettype wire
